// ---- inc/regfile_pkg.sv ----
// Shared constants, types and helper functions for the core register file block.
// Assumes a single system clock and an instruction decoder that fills the request structs.
package regfile_pkg;

  // Register file and data-space layout.
  localparam int          NUM_REGS      = 32;
  localparam logic [4:0]  UPPER_HALF    = 5'h10;
  localparam logic [4:0]  PTR_X_LOW     = 5'h1A;
  localparam logic [4:0]  PTR_Y_LOW     = 5'h1C;
  localparam logic [4:0]  PTR_Z_LOW     = 5'h1E;
  localparam logic [15:0] REG_LAST      = 16'h001F;
  localparam logic [15:0] IO_BASE       = 16'h0020;
  localparam logic [15:0] IO_LAST       = 16'h005F;
  localparam logic [15:0] SRAM_BASE     = 16'h0060;
  localparam logic [15:0] SRAM_LAST     = 16'h00DF;
  localparam int          SRAM_BYTES    = 128;
  localparam int          EEPROM_BYTES  = 128;
  localparam logic [7:0]  UNMAPPED_READ = 8'hFF;

  // Program space layout.
  localparam int          PC_WIDTH      = 10;
  localparam logic [9:0]  PC_RESET      = 10'h000;
  localparam logic [9:0]  PC_ONE        = 10'h001;
  localparam logic [15:0] PTR_ONE       = 16'h0001;
  localparam logic [7:0]  BYTE_ZERO     = 8'h00;

  typedef enum logic [2:0] {
    MODE_NONE     = 3'b000,
    MODE_IO       = 3'b001,
    MODE_DIRECT   = 3'b011,
    MODE_DISP     = 3'b010,
    MODE_INDIRECT = 3'b110,
    MODE_PREDEC   = 3'b111,
    MODE_POSTINC  = 3'b101
  } addr_mode_type;

  typedef enum logic [1:0] {PTR_X = 2'b00, PTR_Y = 2'b01, PTR_Z = 2'b11} ptr_sel_type;

  typedef enum logic [1:0] {PC_STEP = 2'b00, PC_HOLD = 2'b01, PC_POINTER = 2'b11, PC_OFFSET = 2'b10} pc_mode_type;

  typedef enum logic [1:0] {REGION_REG = 2'b00, REGION_IO = 2'b01, REGION_SRAM = 2'b11, REGION_NONE = 2'b10} region_type;

  typedef struct packed {
    logic       write;
    logic       imm_form;
    logic [4:0] dst;
    logic [4:0] src;
    logic [7:0] imm;
  } alu_req_type;

  typedef struct packed {
    logic          valid;
    logic          store;
    addr_mode_type mode;
    ptr_sel_type   ptr;
    logic [5:0]    disp;
    logic [5:0]    io_addr;
    logic [15:0]   direct_addr;
    logic [4:0]    data_reg;
  } mem_req_type;

  typedef struct packed {
    pc_mode_type       mode;
    logic signed [11:0] offset;
  } pc_req_type;

  typedef struct packed {
    logic       rd;
    logic       wr;
    logic [6:0] addr;
    logic [7:0] wdata;
  } ee_req_type;

  // Classifies a data-space address into the region that answers it.
  function automatic region_type region_of(input logic [15:0] addr);
    if (addr <= REG_LAST) begin
      return REGION_REG;
    end else if (addr <= IO_LAST) begin
      return REGION_IO;
    end else if (addr <= SRAM_LAST) begin
      return REGION_SRAM;
    end
    return REGION_NONE;
  endfunction

endpackage

// ---- src/cpu_regfile_data_addressing.sv ----
// Register file, data-space decode and program address logic of a small 8-bit core.
// Assumes the decoder and ALU share SYS_CLK and that I/O read data is valid in the request cycle.
module cpu_regfile_data_addressing (
  input  wire logic                     SYS_CLK,
  input  wire logic                     RESET_N,
  input  wire regfile_pkg::alu_req_type ALU_REQ,
  input  wire logic [7:0]               ALU_RESULT,
  output logic [7:0]                    OPERAND_A,
  output logic [7:0]                    OPERAND_B,
  input  wire regfile_pkg::mem_req_type MEM_REQ,
  output logic [15:0]                   MEM_ADDR,
  output regfile_pkg::region_type       MEM_REGION,
  output logic [7:0]                    LOAD_DATA,
  output logic [5:0]                    IO_ADDR,
  output logic                          IO_RD,
  output logic                          IO_WR,
  output logic [7:0]                    IO_WDATA,
  input  wire logic [7:0]               IO_RDATA,
  input  wire regfile_pkg::pc_req_type  PC_REQ,
  output logic [9:0]                    PROG_ADDR,
  input  wire logic                     CONST_REQ,
  output logic [14:0]                   CONST_WORD_ADDR,
  input  wire logic [15:0]              CONST_WORD,
  output logic [7:0]                    CONST_BYTE,
  input  wire regfile_pkg::ee_req_type  EE_REQ,
  output logic [7:0]                    EE_RDATA
);

  // Storage arrays; the data and nonvolatile stores are not reset on purpose.
  logic [7:0] work_reg [regfile_pkg::NUM_REGS];
  logic [7:0] sram [regfile_pkg::SRAM_BYTES];
  logic [7:0] nv_store [regfile_pkg::EEPROM_BYTES];

  logic [7:0]  next_reg [regfile_pkg::NUM_REGS];
  logic [9:0]  pc;
  logic [9:0]  next_pc;
  logic [7:0]  load_data;
  logic [7:0]  const_byte;
  logic [7:0]  ee_rdata;

  logic [4:0]  alu_dst;
  logic [4:0]  alu_src;
  logic [15:0] ptr_x;
  logic [15:0] ptr_y;
  logic [15:0] ptr_z;
  logic [15:0] mem_addr;
  logic        ptr_we;
  logic [15:0] ptr_next;
  logic [4:0]  ptr_low_index;
  logic [6:0]  sram_index;
  logic [7:0]  store_byte;
  logic [7:0]  load_byte;
  logic        mem_load;
  logic        mem_store;
  regfile_pkg::region_type region;

  // Immediate forms have a 4-bit destination field, forced into the upper half.
  assign alu_dst = ALU_REQ.imm_form ? (regfile_pkg::UPPER_HALF | ALU_REQ.dst) : ALU_REQ.dst;
  assign alu_src = ALU_REQ.src;

  // Operand A and the register form of operand B are read straight from the file so the ALU finishes within the cycle.
  assign OPERAND_A = work_reg[alu_dst];
  assign OPERAND_B = ALU_REQ.imm_form ? ALU_REQ.imm : work_reg[alu_src];

  // The three pointer pairs, low byte at the even register.
  assign ptr_x = {work_reg[regfile_pkg::PTR_X_LOW + 5'h01], work_reg[regfile_pkg::PTR_X_LOW]};
  assign ptr_y = {work_reg[regfile_pkg::PTR_Y_LOW + 5'h01], work_reg[regfile_pkg::PTR_Y_LOW]};
  assign ptr_z = {work_reg[regfile_pkg::PTR_Z_LOW + 5'h01], work_reg[regfile_pkg::PTR_Z_LOW]};

  operand_addr_gen i_operand_addr_gen (
    .req      (MEM_REQ),
    .ptr_x    (ptr_x),
    .ptr_y    (ptr_y),
    .ptr_z    (ptr_z),
    .addr     (mem_addr),
    .ptr_we   (ptr_we),
    .ptr_next (ptr_next)
  );

  // Region decode of the operand address; above the SRAM nothing answers.
  assign region     = regfile_pkg::region_of(mem_addr);
  assign mem_load   = MEM_REQ.valid && !MEM_REQ.store;
  assign mem_store  = MEM_REQ.valid && MEM_REQ.store;
  assign sram_index = 7'(mem_addr - regfile_pkg::SRAM_BASE);
  assign store_byte = work_reg[MEM_REQ.data_reg];
  assign ptr_low_index = (MEM_REQ.ptr == regfile_pkg::PTR_X) ? regfile_pkg::PTR_X_LOW :
                         (MEM_REQ.ptr == regfile_pkg::PTR_Y) ? regfile_pkg::PTR_Y_LOW :
                         regfile_pkg::PTR_Z_LOW;

  // I/O side: location is the data address less the I/O base, strobes last one cycle.
  assign IO_ADDR    = 6'(mem_addr - regfile_pkg::IO_BASE);
  assign IO_RD      = mem_load && (region == regfile_pkg::REGION_IO);
  assign IO_WR      = mem_store && (region == regfile_pkg::REGION_IO);
  assign IO_WDATA   = store_byte;
  assign MEM_ADDR   = mem_addr;
  assign MEM_REGION = region;

  // Load data selection; an unmapped address yields a fixed filler byte.
  always_comb begin
    unique case (region)
      regfile_pkg::REGION_REG:  load_byte = work_reg[mem_addr[4:0]];
      regfile_pkg::REGION_IO:   load_byte = IO_RDATA;
      regfile_pkg::REGION_SRAM: load_byte = sram[sram_index];
      regfile_pkg::REGION_NONE: load_byte = regfile_pkg::UNMAPPED_READ;
    endcase
  end

  // Next register file contents. Later writers win: pointer update, store, load, ALU.
  // A load whose target is the moving pointer therefore overrides the pointer update.
  always_comb begin
    for (int i = 0; i < regfile_pkg::NUM_REGS; i++) begin
      next_reg[i] = work_reg[i];
    end
    if (ptr_we) begin
      next_reg[ptr_low_index]         = ptr_next[7:0];
      next_reg[ptr_low_index + 5'h01] = ptr_next[15:8];
    end
    if (mem_store && (region == regfile_pkg::REGION_REG)) begin
      next_reg[mem_addr[4:0]] = store_byte;
    end
    if (mem_load) begin
      next_reg[MEM_REQ.data_reg] = load_byte;
    end
    if (ALU_REQ.write) begin
      next_reg[alu_dst] = ALU_RESULT;
    end
  end

  // Working registers clear at reset so pointers start at a known address.
  always_ff @(posedge SYS_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      for (int i = 0; i < regfile_pkg::NUM_REGS; i++) begin
        work_reg[i] <= regfile_pkg::BYTE_ZERO;
      end
    end else begin
      work_reg <= next_reg;
    end
  end

  // SRAM writes; stores past 0xDF are dropped by the region check.
  always_ff @(posedge SYS_CLK) begin
    if (mem_store && (region == regfile_pkg::REGION_SRAM)) begin
      sram[sram_index] <= store_byte;
    end
  end

  // Program counter: step, hold, pointer jump or offset jump, all modulo 1024 words.
  always_comb begin
    unique case (PC_REQ.mode)
      regfile_pkg::PC_STEP:    next_pc = pc + regfile_pkg::PC_ONE;
      regfile_pkg::PC_HOLD:    next_pc = pc;
      regfile_pkg::PC_POINTER: next_pc = ptr_z[9:0];
      regfile_pkg::PC_OFFSET:  next_pc = pc + PC_REQ.offset[9:0] + regfile_pkg::PC_ONE;
    endcase
  end

  // The offset is 12 bits wide but only its low 10 bits matter in a 1K space.
  always_ff @(posedge SYS_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      pc <= regfile_pkg::PC_RESET;
    end else begin
      pc <= next_pc;
    end
  end

  assign PROG_ADDR = pc;

  // Constant load: word address from the upper 15 pointer bits, byte chosen by bit 0.
  assign CONST_WORD_ADDR = ptr_z[15:1];

  always_ff @(posedge SYS_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      const_byte <= regfile_pkg::BYTE_ZERO;
    end else if (CONST_REQ) begin
      const_byte <= ptr_z[0] ? CONST_WORD[15:8] : CONST_WORD[7:0];
    end
  end

  assign CONST_BYTE = const_byte;

  // Registered copy of every load so the host sees a stable byte after the access.
  always_ff @(posedge SYS_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      load_data <= regfile_pkg::BYTE_ZERO;
    end else if (mem_load) begin
      load_data <= load_byte;
    end
  end

  assign LOAD_DATA = load_data;

  // Nonvolatile store: its own address space, one byte per access, read first.
  always_ff @(posedge SYS_CLK) begin
    if (EE_REQ.wr) begin
      nv_store[EE_REQ.addr] <= EE_REQ.wdata;
    end
  end

  always_ff @(posedge SYS_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      ee_rdata <= regfile_pkg::BYTE_ZERO;
    end else if (EE_REQ.rd) begin
      ee_rdata <= nv_store[EE_REQ.addr];
    end
  end

  assign EE_RDATA = ee_rdata;

endmodule

// ---- src/operand_addr_gen.sv ----
// Operand address generator for the data-space addressing modes.
// Assumes pointer values are the current register contents and that results are used in the same cycle.
module operand_addr_gen (
  input  wire regfile_pkg::mem_req_type req,
  input  wire logic [15:0]              ptr_x,
  input  wire logic [15:0]              ptr_y,
  input  wire logic [15:0]              ptr_z,
  output logic [15:0]                   addr,
  output logic                          ptr_we,
  output logic [15:0]                   ptr_next
);

  logic [15:0] base;
  logic [15:0] decremented;
  logic [15:0] incremented;
  logic [15:0] displaced;

  // Pointer selection and the three pointer arithmetic results; all wrap at 16 bits.
  assign base        = (req.ptr == regfile_pkg::PTR_X) ? ptr_x :
                       (req.ptr == regfile_pkg::PTR_Y) ? ptr_y : ptr_z;
  assign decremented = base - regfile_pkg::PTR_ONE;
  assign incremented = base + regfile_pkg::PTR_ONE;
  assign displaced   = base + {10'h000, req.disp};

  // Operand address per mode; the post-increment access sees the old value.
  always_comb begin
    addr     = base;
    ptr_we   = 1'b0;
    ptr_next = base;
    unique case (req.mode)
      regfile_pkg::MODE_NONE:     addr = base;
      regfile_pkg::MODE_IO:       addr = regfile_pkg::IO_BASE + {10'h000, req.io_addr};
      regfile_pkg::MODE_DIRECT:   addr = req.direct_addr;
      regfile_pkg::MODE_DISP:     addr = displaced;
      regfile_pkg::MODE_INDIRECT: addr = base;
      regfile_pkg::MODE_PREDEC: begin
        addr     = decremented;
        ptr_we   = req.valid;
        ptr_next = decremented;
      end
      regfile_pkg::MODE_POSTINC: begin
        addr     = base;
        ptr_we   = req.valid;
        ptr_next = incremented;
      end
      default:                    addr = base;
    endcase
  end

endmodule

// ---- test/alu_io_model.sv ----
// Model of the core side: a move-only ALU, an I/O responder and program words.
// Assumes it sits on the same clock as the register file block.
module alu_io_model (
  input  wire logic        sys_clk,
  input  wire logic [7:0]  operand_b,
  input  wire logic        io_rd,
  input  wire logic [5:0]  io_addr,
  input  wire logic [14:0] const_word_addr,
  output logic [7:0]       alu_result,
  output logic [7:0]       io_rdata,
  output logic [15:0]      const_word
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [7:0] idle = 8'h00;
  // Outside a read strobe the bus stays at 0x00, since idle starts at zero and its negation stays zero.
  always @(posedge sys_clk) begin
    idle <= ~idle + 8'h01;
  end
  // Every write acts as a move of operand B; words derive from their address.
  assign alu_result = operand_b;
  assign io_rdata   = io_rd ? {2'h2, io_addr} : idle;
  assign const_word = {const_word_addr[7:0] ^ 8'hC3, const_word_addr[7:0]};
endmodule

// ---- test/regfile_monitor.sv ----
// Concurrent checks on the ports of the register file block.
// Assumes one clock and no register write into a pointer during a pointer access.
module regfile_monitor (
  input wire logic                     SYS_CLK,
  input wire logic                     RESET_N,
  input wire regfile_pkg::alu_req_type ALU_REQ,
  input wire logic [7:0]               ALU_RESULT,
  input wire logic [7:0]               OPERAND_A,
  input wire logic [7:0]               OPERAND_B,
  input wire regfile_pkg::mem_req_type MEM_REQ,
  input wire logic [15:0]              MEM_ADDR,
  input wire regfile_pkg::region_type  MEM_REGION,
  input wire logic [7:0]               LOAD_DATA,
  input wire logic [5:0]               IO_ADDR,
  input wire logic                     IO_RD,
  input wire logic [7:0]               IO_RDATA,
  input wire regfile_pkg::pc_req_type  PC_REQ,
  input wire logic [9:0]               PROG_ADDR
);
  default clocking cb @(posedge SYS_CLK);
  endclocking
  default disable iff (!RESET_N);
  // Immediate forms land in the upper half, so the written register is worked out here.
  wire logic [4:0]  dst_eff = ALU_REQ.imm_form ? {1'b1, ALU_REQ.dst[3:0]} : ALU_REQ.dst;
  wire logic [15:0] io_off  = MEM_ADDR - 16'h0020;
  wire logic        loading = MEM_REQ.valid && !MEM_REQ.store;
  // A write followed by a read of the same register.
  sequence s_alu_write;
    ALU_REQ.write ##1 dst_eff == $past(dst_eff);
  endsequence
  // A pointer access followed by a plain access through the same pointer.
  sequence s_then_plain(regfile_pkg::addr_mode_type m);
    MEM_REQ.valid && MEM_REQ.mode == m && !ALU_REQ.write && MEM_REQ.data_reg < 5'h1A &&
      MEM_REGION != regfile_pkg::REGION_REG ##1 MEM_REQ.valid &&
      MEM_REQ.mode == regfile_pkg::MODE_INDIRECT && MEM_REQ.ptr == $past(MEM_REQ.ptr);
  endsequence
  a_io_window_addr: assert property (MEM_REQ.valid && MEM_REQ.mode == regfile_pkg::MODE_IO |->
    MEM_ADDR == 16'h0020 + MEM_REQ.io_addr && MEM_REGION == regfile_pkg::REGION_IO)
    else $error("I/O address wrong");
  a_io_read_path: assert property (loading && MEM_REGION == regfile_pkg::REGION_IO |->
    IO_RD && IO_ADDR == io_off[5:0] ##1 LOAD_DATA == $past(IO_RDATA))
    else $error("I/O read path wrong");
  a_unmapped_read: assert property (loading && MEM_REGION == regfile_pkg::REGION_NONE |=>
    LOAD_DATA == 8'hFF) else $error("Unmapped read value wrong");
  a_postinc_step: assert property (s_then_plain(regfile_pkg::MODE_POSTINC) |->
    MEM_ADDR == $past(MEM_ADDR) + 16'h0001) else $error("Post-increment wrong");
  a_predec_keep: assert property (s_then_plain(regfile_pkg::MODE_PREDEC) |->
    MEM_ADDR == $past(MEM_ADDR)) else $error("Pre-decrement wrong");
  a_disp_base: assert property (s_then_plain(regfile_pkg::MODE_DISP) |->
    MEM_ADDR == $past(MEM_ADDR) - $past(MEM_REQ.disp)) else $error("Displacement wrong");
  a_imm_operand: assert property (ALU_REQ.imm_form |-> OPERAND_B == ALU_REQ.imm)
    else $error("Immediate operand wrong");
  a_alu_writeback: assert property (s_alu_write |-> OPERAND_A == $past(ALU_RESULT))
    else $error("Result not written back");
  a_pc_offset: assert property (PC_REQ.mode == regfile_pkg::PC_OFFSET |=>
    PROG_ADDR == $past(PROG_ADDR) + $past(PC_REQ.offset[9:0]) + 10'h001) else $error("Offset jump wrong");
endmodule

bind cpu_regfile_data_addressing regfile_monitor i_regfile_monitor (.SYS_CLK, .RESET_N, .ALU_REQ, .ALU_RESULT,
  .OPERAND_A, .OPERAND_B, .MEM_REQ, .MEM_ADDR, .MEM_REGION, .LOAD_DATA, .IO_ADDR, .IO_RD, .IO_RDATA, .PC_REQ,
  .PROG_ADDR);

// ---- test/tb_cpu_regfile_data_addressing.sv ----
// Self-checking bench for the register file block.
// Assumes the checker is bound and the core-side model answers I/O and program words.
module tb_cpu_regfile_data_addressing;
  timeunit 1ns;
  timeprecision 100ps;
  logic                     SYS_CLK = 1'b0;
  logic                     RESET_N = 1'b0;
  logic                     CONST_REQ = 1'b0;
  regfile_pkg::alu_req_type ALU_REQ = '0;
  regfile_pkg::mem_req_type MEM_REQ = '0;
  regfile_pkg::pc_req_type  PC_REQ = '0;
  regfile_pkg::ee_req_type  EE_REQ = '0;
  regfile_pkg::region_type  MEM_REGION;
  logic [7:0]               ALU_RESULT, OPERAND_A, OPERAND_B, LOAD_DATA, IO_WDATA, IO_RDATA, CONST_BYTE, EE_RDATA;
  logic [15:0]              MEM_ADDR, CONST_WORD;
  logic [14:0]              CONST_WORD_ADDR;
  logic [9:0]               PROG_ADDR;
  logic [5:0]               IO_ADDR;
  logic                     IO_RD, IO_WR;
  int                       num_errors = 0;
  int                       checks = 0;
  // Free-running 250 MHz clock.
  always #2 SYS_CLK = ~SYS_CLK;
  cpu_regfile_data_addressing i_cpu_regfile_data_addressing (.SYS_CLK, .RESET_N, .ALU_REQ, .ALU_RESULT, .OPERAND_A,
    .OPERAND_B, .MEM_REQ, .MEM_ADDR, .MEM_REGION, .LOAD_DATA, .IO_ADDR, .IO_RD, .IO_WR, .IO_WDATA, .IO_RDATA,
    .PC_REQ, .PROG_ADDR, .CONST_REQ, .CONST_WORD_ADDR, .CONST_WORD, .CONST_BYTE, .EE_REQ, .EE_RDATA);
  alu_io_model i_alu_io_model (.sys_clk(SYS_CLK), .operand_b(OPERAND_B), .io_rd(IO_RD), .io_addr(IO_ADDR),
    .const_word_addr(CONST_WORD_ADDR), .alu_result(ALU_RESULT), .io_rdata(IO_RDATA), .const_word(CONST_WORD));
  // Inputs change one nanosecond after the edge, clear of the sampling point.
  task automatic tick();
    @(posedge SYS_CLK);
    #1;
  endtask
  task automatic chk(input string n, input logic [15:0] e, input logic [15:0] s);
    checks++;
    if (s !== e) begin
      num_errors++;
      $display("MISMATCH %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic li(input logic [4:0] d, input logic [7:0] v);
    MEM_REQ = '0;
    ALU_REQ = '{write: 1'b1, imm_form: 1'b1, dst: d, src: 5'h00, imm: v};
    tick();
  endtask
  // Holds one access; the caller checks the decode, then lets the edge take it.
  task automatic mem(input logic st, input regfile_pkg::addr_mode_type m, input regfile_pkg::ptr_sel_type p,
                     input logic [15:0] v, input logic [4:0] r);
    ALU_REQ = '0;
    MEM_REQ = '{valid: 1'b1, store: st, mode: m, ptr: p, disp: v[5:0], io_addr: v[5:0], direct_addr: v, data_reg: r};
    #1;
  endtask
  task automatic t_alu();
    li(5'h05, 8'h3C);
    ALU_REQ = '{write: 1'b1, imm_form: 1'b0, dst: 5'h03, src: 5'h15, imm: 8'h00};
    #1;
    chk("operand_b", 16'h003C, {8'h00, OPERAND_B});
    tick();
    ALU_REQ = '{write: 1'b0, imm_form: 1'b0, dst: 5'h03, src: 5'h03, imm: 8'h00};
    #1;
    chk("moved", 16'h003C, {8'h00, OPERAND_A});
    ALU_REQ = '{write: 1'b0, imm_form: 1'b1, dst: 5'h05, src: 5'h00, imm: 8'hA5};
    #1;
    chk("imm dst", 16'h3CA5, {OPERAND_A, OPERAND_B});
    tick();
  endtask
  task automatic t_ptr();
    li(5'h0A, 8'h60);
    li(5'h0B, 8'h00);
    mem(1'b1, regfile_pkg::MODE_POSTINC, regfile_pkg::PTR_X, 16'h0000, 5'h15);
    chk("postinc", 16'hC060, {MEM_REGION, MEM_ADDR[13:0]});
    tick();
    mem(1'b0, regfile_pkg::MODE_INDIRECT, regfile_pkg::PTR_X, 16'h0000, 5'h00);
    chk("indirect", 16'h0061, MEM_ADDR);
    tick();
    mem(1'b0, regfile_pkg::MODE_PREDEC, regfile_pkg::PTR_X, 16'h0000, 5'h00);
    chk("predec", 16'h0060, MEM_ADDR);
    tick();
    chk("sram back", 16'h003C, {8'h00, LOAD_DATA});
    li(5'h0A, 8'h00);
    mem(1'b0, regfile_pkg::MODE_PREDEC, regfile_pkg::PTR_X, 16'h0000, 5'h00);
    chk("wrap", 16'hFFFF, MEM_ADDR);
    tick();
    // A plain access right after the decrement sees the stored, already lowered pointer.
    mem(1'b0, regfile_pkg::MODE_INDIRECT, regfile_pkg::PTR_X, 16'h0000, 5'h00);
    chk("predec kept", 16'hFFFF, MEM_ADDR);
    tick();
    chk("unmapped", 16'h00FF, {8'h00, LOAD_DATA});
  endtask
  task automatic t_io();
    mem(1'b0, regfile_pkg::MODE_IO, regfile_pkg::PTR_X, 16'h003F, 5'h01);
    chk("io read", 16'h7F5F, {1'b0, IO_RD, IO_ADDR, MEM_ADDR[7:0]});
    tick();
    chk("io load", 16'h00BF, {8'h00, LOAD_DATA});
    mem(1'b1, regfile_pkg::MODE_IO, regfile_pkg::PTR_X, 16'h0001, 5'h15);
    chk("io store", 16'h013C, {7'h00, IO_WR, IO_WDATA});
    tick();
    mem(1'b0, regfile_pkg::MODE_DIRECT, regfile_pkg::PTR_X, 16'h0015, 5'h02);
    chk("direct", 16'h0015, MEM_ADDR);
    tick();
    chk("reg as mem", 16'h003C, {8'h00, LOAD_DATA});
  endtask
  task automatic t_prog();
    li(5'h0E, 8'h41);
    li(5'h0F, 8'h00);
    mem(1'b0, regfile_pkg::MODE_DISP, regfile_pkg::PTR_Z, 16'h003F, 5'h01);
    chk("disp", 16'h0080, MEM_ADDR);
    tick();
    mem(1'b0, regfile_pkg::MODE_INDIRECT, regfile_pkg::PTR_Z, 16'h0000, 5'h01);
    tick();
    MEM_REQ = '0;
    CONST_REQ = 1'b1;
    PC_REQ = '{mode: regfile_pkg::PC_POINTER, offset: 12'h000};
    #1;
    chk("word addr", 16'h0020, {1'b0, CONST_WORD_ADDR});
    tick();
    chk("const byte", 16'h00E3, {8'h00, CONST_BYTE});
    chk("pointer jump", 16'h0041, {6'h00, PROG_ADDR});
    CONST_REQ = 1'b0;
    PC_REQ = '{mode: regfile_pkg::PC_OFFSET, offset: 12'h800};
    tick();
    chk("offset back", 16'h0042, {6'h00, PROG_ADDR});
    PC_REQ.offset = 12'h7FF;
    tick();
    chk("offset wrap", 16'h0042, {6'h00, PROG_ADDR});
  endtask
  task automatic t_ee();
    EE_REQ = '{rd: 1'b0, wr: 1'b1, addr: 7'h7F, wdata: 8'h5A};
    tick();
    EE_REQ = '{rd: 1'b1, wr: 1'b0, addr: 7'h7F, wdata: 8'h00};
    tick();
    chk("nonvolatile", 16'h005A, {8'h00, EE_RDATA});
  endtask
  task automatic print_verdict();
    $display("checks %0d num_errors %0d", checks, num_errors);
    if (num_errors == 0 && checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  // Reset for twelve cycles, then the scenarios in turn.
  initial begin
    repeat (12) @(posedge SYS_CLK);
    #1;
    RESET_N = 1'b1;
    tick();
    t_alu();
    t_ptr();
    t_io();
    t_prog();
    t_ee();
    print_verdict();
  end
  // The scenarios need under forty cycles; fifty times that means a hang.
  initial begin
    #8000;
    num_errors++;
    print_verdict();
  end
endmodule
